// *** test_udw_host.sv ***
module test_udw_host;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, rst_n = 0, vld = 0, up = 0, hv = 0, endh = 0, sup = 1;
  logic [5:0] steps = 0, pw, wm, exp_w = 6'h1F;
  logic       rdy, sl, se, ud, dn;
  logic [5:0] q[$];
  int         n_mismatch = 0, n_compared = 0, seed = 32'h3B3B6E5D;
  always #25 clk = ~clk;
  udw_host DUT (.ref_clk_i(clk), .resetn_i(rst_n), .cmd_valid_i(vld), .cmd_ready_o(rdy),
    .cmd_up_i(up), .cmd_hv_i(hv), .cmd_end_high_i(endh), .cmd_steps_i(steps),
    .supply_ok_i(sup), .sel_low_o(sl), .sel_elevated_level_o(se), .updown_o(ud),
    .wiper_model_o(wm), .done_o(dn));
  udw_pot_model POT (.sel_low_i(sl), .sel_elevated_level_i(se), .updown_i(ud),
    .supply_ok_i(sup), .wiper_o(pw));
  task automatic chk(string nm, logic [5:0] e, logic [5:0] s);
    n_compared++;
    if (s !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, s);
      n_mismatch++;
    end
  endtask : chk
  task automatic idle();
    int k;
    k = 0;
    while (rdy !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
  endtask : idle
  task automatic cmd(logic u, logic h, logic eh, logic [5:0] n);
    for (int k = 0; k < n; k++)
      exp_w = u ? (exp_w == 6'h3F ? exp_w : exp_w + 6'h01)
                : (exp_w == 6'h00 ? exp_w : exp_w - 6'h01);
    q.push_back(exp_w);
    idle();
    {up, hv, endh, steps, vld} = {u, h, eh, n, 1'b1};
    @(negedge clk);
    vld = 0;
  endtask : cmd
  always @(negedge clk) if (dn === 1'b1) begin
    chk("wiper_model", q[0], wm);
    chk("pot_wiper", q[0], pw);
    q.pop_front();
  end
  task finish_test;
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    for (int i = 0; i < 8; i++) cmd(i[0], i[1], i[2], 6'($random(seed)));
    cmd(1, 0, 0, 6'h3F);
    cmd(1, 1, 1, 6'h01);
    cmd(0, 0, 1, 6'h3F);
    cmd(0, 1, 0, 6'h00);
    cmd(0, 0, 0, 6'h02);
    idle();
    sup = 0;
    repeat (20) @(negedge clk);
    sup = 1;
    repeat (10) @(negedge clk);
    exp_w = 6'h1F;
    chk("reload_model", 6'h1F, wm);
    chk("reload_pot", 6'h1F, pw);
    cmd(1, 0, 0, 6'h05);
    cmd(0, 1, 1, 6'h03);
    idle();
    repeat (2) @(negedge clk);
    chk("pending", 6'h00, 6'(q.size()));
    finish_test();
  end
endmodule : test_udw_host
bind udw_host udw_host_assertions CHK (.ref_clk_i, .resetn_i, .cmd_valid_i, .cmd_ready_o,
  .supply_ok_i, .sel_low_o, .sel_elevated_level_o, .updown_o, .wiper_model_o, .done_o);

// *** udw_host.sv ***
module udw_host
  import udw_pkg::*;
(
  input  wire logic               ref_clk_i,
  input  wire logic               resetn_i,
  input  wire logic               cmd_valid_i,
  output logic                    cmd_ready_o,
  input  wire logic               cmd_up_i,
  input  wire logic               cmd_hv_i,
  input  wire logic               cmd_end_high_i,
  input  wire logic [WIPER_W-1:0] cmd_steps_i,
  input  wire logic               supply_ok_i,
  output logic                    sel_low_o,
  output logic                    sel_elevated_level_o,
  output logic                    updown_o,
  output logic [WIPER_W-1:0]      wiper_model_o,
  output logic                    done_o
);
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_SETUP = 6'b000010,
    ST_SEL   = 6'b000100,
    ST_RISE  = 6'b001000,
    ST_FALL  = 6'b010000,
    ST_END   = 6'b100000
  } udw_state_t;

  typedef struct packed {
    udw_state_t         state;
    logic [2:0]         sup_sync;
    logic               sup_ok;
    logic               up;
    logic               hv;
    logic               end_high;
    logic [WIPER_W-1:0] steps;
    logic [WIPER_W-1:0] wiper;
    udw_sel_t           sel;
    logic               ud;
    logic               done;
  } udw_host_st_t;

  udw_host_st_t st_reg;
  udw_host_st_t st_next;
  udw_tick_if   tk ();

  // Level left on up/down when a frame closes with no steps to go.
  // Raising it while selected would be one more step, so only a high
  // line that is already high may stay high.
  function automatic logic udw_close_level(input logic cur, input logic want_high);
    udw_close_level = cur & want_high;
  endfunction : udw_close_level

  // True once the step counter has run out
  function automatic logic udw_last(input logic [WIPER_W-1:0] n);
    udw_last = (n == '0);
  endfunction : udw_last

  udw_tick u_tick (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .tk        (tk.src)
  );

  assign tk.clear = (st_reg.state == ST_IDLE);

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.sup_sync = {st_reg.sup_sync[1:0], supply_ok_i};
    if (st_reg.sup_sync[2] == st_reg.sup_sync[1]) begin
      st_next.sup_ok = st_reg.sup_sync[2];
    end
    // Supply recovery reloads the model of the device wiper
    if (st_next.sup_ok && !st_reg.sup_ok) begin
      st_next.wiper = WIPER_DEFAULT;
    end
    unique case (st_reg.state)
      ST_IDLE: begin
        st_next.sel = UDW_SEL_HIGH;
        if (cmd_valid_i && st_reg.sup_ok) begin
          st_next.up = cmd_up_i;
          st_next.hv = cmd_hv_i;
          st_next.end_high = cmd_end_high_i;
          st_next.steps = cmd_steps_i;
          st_next.ud = cmd_up_i;
          st_next.state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (tk.tick) begin
          // Leave select high only after direction has settled
          st_next.sel = st_reg.hv ? UDW_SEL_HV : UDW_SEL_LOW;
          st_next.state = ST_SEL;
        end
      end
      ST_SEL: begin
        if (tk.tick) begin
          if (udw_last(st_reg.steps)) begin
            st_next.ud = udw_close_level(st_reg.ud, st_reg.end_high);
            st_next.state = ST_END;
          end else begin
            // Low phase ahead of the first counted rising edge
            st_next.ud = 1'b0;
            st_next.state = ST_RISE;
          end
        end
      end
      ST_RISE: begin
        if (tk.tick) begin
          st_next.ud = 1'b1;
          st_next.wiper = udw_step(st_reg.wiper, st_reg.up);
          st_next.steps = st_reg.steps - WIPER_W'(1);
          st_next.state = ST_FALL;
        end
      end
      ST_FALL: begin
        if (tk.tick) begin
          if (udw_last(st_reg.steps)) begin
            // Line is high after the last step; keep it if asked to end high
            st_next.ud = udw_close_level(st_reg.ud, st_reg.end_high);
            st_next.state = ST_END;
          end else begin
            st_next.ud = 1'b0;
            st_next.state = ST_RISE;
          end
        end
      end
      ST_END: begin
        if (tk.tick) begin
          // Only a falling edge is harmless while selected; never raise here
          if (st_reg.ud && !st_reg.end_high) begin
            st_next.ud = 1'b0;
          end else begin
            st_next.sel = UDW_SEL_HIGH;
            st_next.done = 1'b1;
            st_next.state = ST_IDLE;
          end
        end
      end
    endcase
    // Abort to an idle bus if supply drops mid-command
    if (!st_reg.sup_ok) begin
      st_next.sel = UDW_SEL_HIGH;
      st_next.ud = 1'b0;
      st_next.state = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      st_reg.state <= ST_IDLE;
      st_reg.sup_sync <= 3'h0;
      st_reg.sup_ok <= 1'b0;
      st_reg.up <= 1'b0;
      st_reg.hv <= 1'b0;
      st_reg.end_high <= 1'b0;
      st_reg.steps <= 6'h00;
      st_reg.wiper <= WIPER_DEFAULT;
      st_reg.sel <= UDW_SEL_HIGH;
      st_reg.ud <= 1'b0;
      st_reg.done <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Wiper is a host-side model only; the device gives no readback
  assign wiper_model_o = st_reg.wiper;
  assign cmd_ready_o = (st_reg.state == ST_IDLE) && st_reg.sup_ok;
  assign sel_low_o = (st_reg.sel == UDW_SEL_LOW);
  assign sel_elevated_level_o = (st_reg.sel == UDW_SEL_HV);
  assign updown_o = st_reg.ud;
  assign done_o = st_reg.done;
endmodule : udw_host

// *** udw_host_assertions.sv ***
module udw_host_assertions (
  input wire logic       ref_clk_i,
  input wire logic       resetn_i,
  input wire logic       cmd_valid_i,
  input wire logic       cmd_ready_o,
  input wire logic       supply_ok_i,
  input wire logic       sel_low_o,
  input wire logic       sel_elevated_level_o,
  input wire logic       updown_o,
  input wire logic [5:0] wiper_model_o,
  input wire logic       done_o
);
  logic sel_any;
  assign sel_any = sel_low_o | sel_elevated_level_o;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  AST_SEL_ONE: assert property (!(sel_low_o && sel_elevated_level_o))
    else $error("both select levels driven");
  AST_RESET_MID: assert property ($rose(resetn_i) |-> wiper_model_o == 6'h1F)
    else $error("wiper not mid-scale after reset");
  AST_STEP_ONE: assert property ($changed(wiper_model_o) && $past(sel_any) |->
    (wiper_model_o - $past(wiper_model_o) == 6'h01) || ($past(wiper_model_o) - wiper_model_o == 6'h01))
    else $error("wiper moved more than one tap");
  AST_TOP: assert property ($past(wiper_model_o) == 6'h3F && sel_any |-> wiper_model_o != 6'h00)
    else $error("wiper wrapped at top");
  AST_BOT: assert property ($past(wiper_model_o) == 6'h00 && sel_any |-> wiper_model_o != 6'h3F)
    else $error("wiper wrapped at bottom");
  AST_IDLE: assert property (!sel_any && !$past(sel_any) && $changed(wiper_model_o) |->
    wiper_model_o == 6'h1F) else $error("wiper moved while idle");
  AST_DIR_SETUP: assert property ($rose(sel_any) |-> $stable(updown_o))
    else $error("direction changed at select");
  AST_TAKE: assert property (cmd_valid_i && cmd_ready_o |=> !cmd_ready_o)
    else $error("ready stayed high after take");
  AST_DONE: assert property (done_o |-> !sel_any && ($past(sel_any) || $past(sel_any, 2)))
    else $error("done without frame end");
  AST_ABORT: assert property (!supply_ok_i [*6] |-> !sel_any)
    else $error("frame kept during low supply");
endmodule : udw_host_assertions

// *** udw_pkg.sv ***
package udw_pkg;
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned WIPER_W         = 6;
  localparam int unsigned TAPS            = 64;
  localparam logic [5:0]  WIPER_MIN       = 6'h00;
  localparam logic [5:0]  WIPER_MAX       = 6'h3F;
  localparam logic [5:0]  WIPER_DEFAULT   = 6'h1F;
  // Pin timing, in ns; cycle counts round up
  localparam int unsigned T_SETUP_NS      = 500;
  localparam int unsigned T_HALF_NS       = 500;
  localparam int unsigned T_SETUP_CYC     = (T_SETUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned T_HALF_CYC      = (T_HALF_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned CNT_W           = 8;

  typedef enum logic [1:0] {
    UDW_SEL_LOW  = 2'h0,
    UDW_SEL_HIGH = 2'h1,
    UDW_SEL_HV   = 2'h2
  } udw_sel_t;

  function automatic logic [5:0] udw_step(input logic [5:0] w, input logic up);
    if (up) begin
      udw_step = (w == WIPER_MAX) ? w : w + 6'h01;
    end else begin
      udw_step = (w == WIPER_MIN) ? w : w - 6'h01;
    end
  endfunction : udw_step
endpackage : udw_pkg

// *** udw_pot_model.sv ***
module udw_pot_model (
  input wire logic  sel_low_i,
  input wire logic  sel_elevated_level_i,
  input wire logic  updown_i,
  input wire logic  supply_ok_i,
  output logic [5:0] wiper_o = 6'h1F
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sel;
  logic up;
  assign sel = sel_low_i | sel_elevated_level_i;
  always @(posedge sel) up = updown_i;
  always @(posedge supply_ok_i) wiper_o = 6'h1F;
  always @(posedge updown_i) if (sel && up && wiper_o != 6'h3F) wiper_o++;
  else if (sel && !up && wiper_o != 6'h00) wiper_o--;
endmodule : udw_pot_model

// *** udw_tick.sv ***
module udw_tick
  import udw_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  udw_tick_if.src   tk
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } udw_tick_st_t;

  udw_tick_st_t st_reg;
  udw_tick_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (tk.clear) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt == CNT_W'(T_HALF_CYC - 1)) begin
      st_next.cnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tk.tick = st_reg.tick;
endmodule : udw_tick

// *** udw_tick_if.sv ***
interface udw_tick_if;
  logic tick;
  logic clear;
  modport src (output tick, input clear);
  modport dst (input tick, output clear);
endinterface : udw_tick_if
